//--- design/bcc_clock.sv
// BCD clock calendar with APB registers, backup and interrupt
`timescale 1ns/100ps
module bcc_clock #(
    parameter int TICK_CYCLES = bcc_pkg::TICK_CYCLES,
    parameter int BACKUP_S    = bcc_pkg::BACKUP_SECONDS
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [bcc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       main_power_ok,
    output logic                            clock_invalid_flag,
    output logic                            irq
);
    localparam int OFF_W = $clog2(BACKUP_S + 1);
    localparam logic [OFF_W-1:0] OFF_LIMIT = OFF_W'(BACKUP_S);
    localparam int IW = bcc_pkg::IRQ_W;

    // Bus state
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] rd_val;
    logic        rd_err;
    logic        acc;
    logic        wr_done;
    logic        rd_done;

    // Time state
    bcc_pkg::bcc_time_t time_ff;
    bcc_pkg::bcc_time_t nxt_time;
    bcc_pkg::bcc_time_t stage_ff;
    logic               day_roll;
    logic [2:0]         set_wday;
    logic               tick;
    logic               apply;

    // Backup and validity state
    logic [OFF_W-1:0] off_cnt_ff;
    logic             drained_ff;
    logic             power_ff;
    logic             invalid_ff;
    logic             raise_invalid;

    // Interrupt state
    logic [IW-1:0] irq_sts_ff;
    logic [IW-1:0] irq_msk_ff;
    logic [IW-1:0] irq_ev;
    logic          irq_ff;

    // One wait state: first access cycle loads data, second completes
    assign acc     = psel && penable;
    assign wr_done = acc && pready_ff && pwrite;
    assign rd_done = acc && pready_ff && !pwrite;

    // [R12] set command pulse
    assign apply = wr_done && (paddr == bcc_pkg::OFF_CTRL)
                   && pwdata[bcc_pkg::CTRL_APPLY];

    bcc_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .restart (apply),
        .tick    (tick)
    );

    // [R8] weekday from staged date
    bcc_weekday u_wday (
        .date    (stage_ff),
        .weekday (set_wday)
    );

    // Read mux; undecoded addresses answer with an error
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        // [R7] low byte of each word
        if (paddr == bcc_pkg::OFF_YEAR) begin
            rd_val = {24'h00_0000, time_ff.year};
        end else if (paddr == bcc_pkg::OFF_MONTH) begin
            rd_val = {24'h00_0000, time_ff.month};
        end else if (paddr == bcc_pkg::OFF_DAY) begin
            rd_val = {24'h00_0000, time_ff.day};
        end else if (paddr == bcc_pkg::OFF_HOUR) begin
            rd_val = {24'h00_0000, time_ff.hour};
        end else if (paddr == bcc_pkg::OFF_MINUTE) begin
            rd_val = {24'h00_0000, time_ff.minute};
        end else if (paddr == bcc_pkg::OFF_SECOND) begin
            rd_val = {24'h00_0000, time_ff.second};
        end else if (paddr == bcc_pkg::OFF_WEEKDAY) begin
            rd_val = {24'h00_0000, time_ff.weekday};
        end else if (paddr == bcc_pkg::OFF_SET_YEAR) begin
            rd_val = {24'h00_0000, stage_ff.year};
        end else if (paddr == bcc_pkg::OFF_SET_MON) begin
            rd_val = {24'h00_0000, stage_ff.month};
        end else if (paddr == bcc_pkg::OFF_SET_DAY) begin
            rd_val = {24'h00_0000, stage_ff.day};
        end else if (paddr == bcc_pkg::OFF_SET_HOUR) begin
            rd_val = {24'h00_0000, stage_ff.hour};
        end else if (paddr == bcc_pkg::OFF_SET_MIN) begin
            rd_val = {24'h00_0000, stage_ff.minute};
        end else if (paddr == bcc_pkg::OFF_SET_SEC) begin
            rd_val = {24'h00_0000, stage_ff.second};
        end else if (paddr == bcc_pkg::OFF_CTRL) begin
            rd_val = 32'h0000_0000;
        end else if (paddr == bcc_pkg::OFF_STATUS) begin
            rd_val = {29'h0000_0000, drained_ff, power_ff, invalid_ff};
        end else if (paddr == bcc_pkg::OFF_IRQ_STS) begin
            rd_val = {29'h0000_0000, irq_sts_ff};
        end else if (paddr == bcc_pkg::OFF_IRQ_MSK) begin
            rd_val = {29'h0000_0000, irq_msk_ff};
        end else begin
            rd_err = 1'b1;
        end
    end

    // Handshake and read data capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (acc && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= rd_err;
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_val;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
    end

    // Staging registers written by software before a set command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_ff.year    <= bcc_pkg::RST_YEAR;
            stage_ff.month   <= bcc_pkg::RST_MONTH;
            stage_ff.day     <= bcc_pkg::RST_DAY;
            stage_ff.hour    <= bcc_pkg::RST_ZERO;
            stage_ff.minute  <= bcc_pkg::RST_ZERO;
            stage_ff.second  <= bcc_pkg::RST_ZERO;
            stage_ff.weekday <= bcc_pkg::RST_ZERO;
        end else if (wr_done) begin
            if (paddr == bcc_pkg::OFF_SET_YEAR) begin
                stage_ff.year <= pwdata[7:0];
            end else if (paddr == bcc_pkg::OFF_SET_MON) begin
                stage_ff.month <= pwdata[7:0];
            end else if (paddr == bcc_pkg::OFF_SET_DAY) begin
                stage_ff.day <= pwdata[7:0];
            end else if (paddr == bcc_pkg::OFF_SET_HOUR) begin
                stage_ff.hour <= pwdata[7:0];
            end else if (paddr == bcc_pkg::OFF_SET_MIN) begin
                stage_ff.minute <= pwdata[7:0];
            end else if (paddr == bcc_pkg::OFF_SET_SEC) begin
                stage_ff.second <= pwdata[7:0];
            end
        end
    end

    // Next calendar value one second later
    always_comb begin
        nxt_time = time_ff;
        day_roll = 1'b0;
        // [R13] carry chain
        if (time_ff.second == bcc_pkg::MAX_MINSEC) begin
            // [R5] wrap at 59
            nxt_time.second = bcc_pkg::RST_ZERO;
            if (time_ff.minute == bcc_pkg::MAX_MINSEC) begin
                nxt_time.minute = bcc_pkg::RST_ZERO;
                // [R4] 24-hour wrap
                if (time_ff.hour == bcc_pkg::MAX_HOUR) begin
                    nxt_time.hour = bcc_pkg::RST_ZERO;
                    day_roll = 1'b1;
                    // [R6] Saturday wraps to Sunday
                    if (time_ff.weekday == bcc_pkg::MAX_WDAY) begin
                        nxt_time.weekday = bcc_pkg::RST_ZERO;
                    end else begin
                        nxt_time.weekday = time_ff.weekday + 8'h01;
                    end
                    // [R3] month length and leap year
                    if (time_ff.day == bcc_pkg::days_in_month(
                            time_ff.month, time_ff.year)) begin
                        nxt_time.day = bcc_pkg::RST_DAY;
                        // [R2] December wraps to January
                        if (time_ff.month == bcc_pkg::MAX_MONTH) begin
                            nxt_time.month = bcc_pkg::RST_MONTH;
                            // [R1] century is not kept
                            if (time_ff.year == bcc_pkg::MAX_YEAR) begin
                                nxt_time.year = bcc_pkg::RST_YEAR;
                            end else begin
                                nxt_time.year = bcc_pkg::bcd_inc(
                                    time_ff.year);
                            end
                        end else begin
                            nxt_time.month = bcc_pkg::bcd_inc(
                                time_ff.month);
                        end
                    end else begin
                        nxt_time.day = bcc_pkg::bcd_inc(time_ff.day);
                    end
                end else begin
                    nxt_time.hour = bcc_pkg::bcd_inc(time_ff.hour);
                end
            end else begin
                nxt_time.minute = bcc_pkg::bcd_inc(time_ff.minute);
            end
        end else begin
            nxt_time.second = bcc_pkg::bcd_inc(time_ff.second);
        end
    end

    // Time registers; a set command wins over a tick in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            time_ff.year    <= bcc_pkg::RST_YEAR;
            time_ff.month   <= bcc_pkg::RST_MONTH;
            time_ff.day     <= bcc_pkg::RST_DAY;
            time_ff.hour    <= bcc_pkg::RST_ZERO;
            time_ff.minute  <= bcc_pkg::RST_ZERO;
            time_ff.second  <= bcc_pkg::RST_ZERO;
            time_ff.weekday <= bcc_pkg::RST_WEEKDAY;
        end else if (apply) begin
            // [R8] setter weekday ignored
            time_ff         <= stage_ff;
            time_ff.weekday <= {5'h00, set_wday};
        end else if (tick && !drained_ff) begin
            // [R9] runs with power absent until the store drains
            time_ff <= nxt_time;
        end
    end

    // Seconds spent without main power; the store drains at the limit.
    // Counting stops once drained, as a dead store would stop the clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ff   <= 1'b1;
            off_cnt_ff <= '0;
            drained_ff <= 1'b0;
        end else begin
            power_ff <= main_power_ok;
            if (main_power_ok) begin
                off_cnt_ff <= '0;
                drained_ff <= 1'b0;
            end else if (tick && !drained_ff) begin
                off_cnt_ff <= off_cnt_ff + 1'b1;
                drained_ff <= (off_cnt_ff + 1'b1) >= OFF_LIMIT;
            end
        end
    end

    // [R10] raise when power returns to a drained store
    assign raise_invalid = main_power_ok && !power_ff && drained_ff;

    // Data is untrusted after power-up until software sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalid_ff <= 1'b1;
        end else if (raise_invalid) begin
            // [R10] raise beats a same-cycle set
            invalid_ff <= 1'b1;
        end else if (apply) begin
            invalid_ff <= 1'b0;
        end
    end

    assign irq_ev[bcc_pkg::IRQ_SECOND]  = tick && !drained_ff && !apply;
    assign irq_ev[bcc_pkg::IRQ_DAY]     = irq_ev[bcc_pkg::IRQ_SECOND]
                                          && day_roll;
    assign irq_ev[bcc_pkg::IRQ_INVALID] = raise_invalid;

    // Sticky events cleared by a status read; a new event survives it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_ff <= '0;
        end else if (rd_done && (paddr == bcc_pkg::OFF_IRQ_STS)) begin
            irq_sts_ff <= irq_ev;
        end else begin
            irq_sts_ff <= irq_sts_ff | irq_ev;
        end
    end

    // Mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_msk_ff <= bcc_pkg::RST_IRQ_MSK;
        end else if (wr_done && (paddr == bcc_pkg::OFF_IRQ_MSK)) begin
            irq_msk_ff <= pwdata[IW-1:0];
        end
    end

    // Interrupt level lags the status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_sts_ff & irq_msk_ff);
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign clock_invalid_flag = invalid_ff;
    assign irq                = irq_ff;

endmodule : bcc_clock

//--- design/bcc_pkg.sv
// Shared constants, types and helpers of the BCD clock calendar
// Notes on behaviour
// [R1] Year holds two BCD digits, no century
// [R2] Month is BCD 01 through 12
// [R3] Day of month is BCD 01 through 31
// [R4] Hour is BCD 00 through 23
// [R5] Minute and second are BCD 00 through 59
// [R6] Weekday 0 Sunday through 6 Saturday
// [R7] Seven consecutive registers, BCD in low byte
// [R8] Weekday computed by device when date set
// [R9] Time keeps counting while main power absent; here counting stops once the backup store drains
// [R10] Flag raised when backup period ran out
// [R11] Software should test flag before trusting time
// [R12] Software or tool loads new date and time
// [R13] Seconds tick carries through full calendar
package bcc_pkg;

    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_YEAR     = 8'h00;
    localparam logic [7:0] OFF_MONTH    = 8'h04;
    localparam logic [7:0] OFF_DAY      = 8'h08;
    localparam logic [7:0] OFF_HOUR     = 8'h0c;
    localparam logic [7:0] OFF_MINUTE   = 8'h10;
    localparam logic [7:0] OFF_SECOND   = 8'h14;
    localparam logic [7:0] OFF_WEEKDAY  = 8'h18;
    localparam logic [7:0] OFF_SET_YEAR = 8'h20;
    localparam logic [7:0] OFF_SET_MON  = 8'h24;
    localparam logic [7:0] OFF_SET_DAY  = 8'h28;
    localparam logic [7:0] OFF_SET_HOUR = 8'h2c;
    localparam logic [7:0] OFF_SET_MIN  = 8'h30;
    localparam logic [7:0] OFF_SET_SEC  = 8'h34;
    localparam logic [7:0] OFF_CTRL     = 8'h38;
    localparam logic [7:0] OFF_STATUS   = 8'h3c;
    localparam logic [7:0] OFF_IRQ_STS  = 8'h40;
    localparam logic [7:0] OFF_IRQ_MSK  = 8'h44;

    // Field positions
    localparam int CTRL_APPLY   = 0;
    localparam int STAT_INVALID = 0;
    localparam int STAT_POWER   = 1;
    localparam int STAT_DRAINED = 2;
    localparam int IRQ_W        = 3;
    localparam int IRQ_SECOND   = 0;
    localparam int IRQ_DAY      = 1;
    localparam int IRQ_INVALID  = 2;

    // Reset values: 2000-01-01 00:00:00, a Saturday
    localparam logic [7:0] RST_YEAR    = 8'h00;
    localparam logic [7:0] RST_MONTH   = 8'h01;
    localparam logic [7:0] RST_DAY     = 8'h01;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_WEEKDAY = 8'h06;
    localparam logic [IRQ_W-1:0] RST_IRQ_MSK = 3'h0;

    // BCD limits
    localparam logic [7:0] MAX_YEAR   = 8'h99;
    localparam logic [7:0] MAX_MONTH  = 8'h12;
    localparam logic [7:0] MAX_HOUR   = 8'h23;
    localparam logic [7:0] MAX_MINSEC = 8'h59;
    localparam logic [7:0] MAX_WDAY   = 8'h06;
    localparam int BASE_YEAR = 2000;

    // Timing
    localparam int CLK_PERIOD_NS  = 50;
    localparam int TICK_PERIOD_MS = 1000;
    localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int BACKUP_HOURS   = 168;
    localparam int BACKUP_SECONDS = BACKUP_HOURS * 3600;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
        logic [7:0] weekday;
    } bcc_time_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic [6:0] bcd2bin(input logic [7:0] v);
        return 7'(v[7:4]) * 7'h0a + 7'(v[3:0]);
    endfunction : bcd2bin

    // Year 00 counts as leap, which holds for 2000
    function automatic logic [7:0] days_in_month(input logic [7:0] m,
                                                 input logic [7:0] y);
        logic [6:0] yb;
        yb = bcd2bin(y);
        case (m)
            8'h02: return (yb[1:0] == 2'h0) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction : days_in_month

endpackage : bcc_pkg

//--- design/bcc_tick_div.sv
// Divider that turns pclk into a one-cycle seconds enable
`timescale 1ns/100ps
module bcc_tick_div #(
    parameter int CYCLES = bcc_pkg::TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic restart,
    output logic      tick
);
    localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_ff;
    logic         tick_ff;

    // Restart aligns the next second to a fresh setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (restart) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (cnt_ff == LAST) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule : bcc_tick_div

//--- design/bcc_weekday.sv
// Weekday of a BCD date, years taken as 2000 to 2099
`timescale 1ns/100ps
module bcc_weekday (
    input  bcc_pkg::bcc_time_t date,
    output logic [2:0]         weekday
);
    logic [6:0]  yb;
    logic [3:0]  mb;
    logic [4:0]  db;
    logic [11:0] yf;
    logic [3:0]  moff;
    logic [15:0] sum;

    // Month offsets of the Sakamoto method, Sunday as zero
    always_comb begin
        case (mb)
            4'h1, 4'h5:  moff = 4'h0;
            4'h2, 4'h6:  moff = 4'h3;
            4'h3, 4'hb:  moff = 4'h2;
            4'h4:        moff = 4'h5;
            4'h7:        moff = 4'h5;
            4'h8:        moff = 4'h1;
            4'h9:        moff = 4'h4;
            4'ha:        moff = 4'h6;
            4'hc:        moff = 4'h4;
            default:     moff = 4'h0;
        endcase
    end

    // Full year minus one for January and February
    always_comb begin
        yb  = bcc_pkg::bcd2bin(date.year);
        mb  = 4'(bcc_pkg::bcd2bin(date.month));
        db  = 5'(bcc_pkg::bcd2bin(date.day));
        yf  = 12'(bcc_pkg::BASE_YEAR) + 12'(yb) - 12'(mb < 4'h3);
        sum = 16'(yf) + 16'(yf >> 2) - 16'(yf / 12'd100)
            + 16'(yf / 12'd400) + 16'(moff) + 16'(db);
        weekday = 3'(sum % 16'd7);
    end

endmodule : bcc_weekday

//--- dv/bcc_clock_asserts.sv
// Port checker of the BCD clock calendar, bound into its top module
`timescale 1ns/100ps
module bcc_clock_asserts (
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [bcc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       main_power_ok,
    input wire logic                       clock_invalid_flag,
    input wire logic                       irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Completed good read and completed apply write
    logic       rd_ok;
    logic       apply_w;
    logic [7:0] v;
    assign rd_ok   = pready && !pwrite && !pslverr;
    assign apply_w = pready && pwrite && paddr == 8'h38 && pwdata[0];
    assign v       = prdata[7:0];

    AST_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
        else $error("pready not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    AST_UNMAPPED: assert property (pready && paddr > 8'h44 |-> pslverr)
        else $error("unmapped place not refused");
    AST_MONTH: assert property (rd_ok && paddr == 8'h04 |->
        v >= 8'h01 && v <= 8'h12) else $error("month out of range");
    AST_DAY: assert property (rd_ok && paddr == 8'h08 |->
        v >= 8'h01 && v <= 8'h31 && v[3:0] <= 4'h9)
        else $error("day out of range");
    AST_HOUR: assert property (rd_ok && paddr == 8'h0c |->
        v <= 8'h23 && v[3:0] <= 4'h9) else $error("hour out of range");
    AST_MINSEC: assert property (rd_ok && paddr inside {8'h10, 8'h14}
        |-> v <= 8'h59 && v[3:0] <= 4'h9) else $error("minute or second bad");
    AST_WEEKDAY: assert property (rd_ok && paddr == 8'h18 |->
        v <= 8'h06) else $error("weekday out of range");
    AST_FLAG_RISE: assert property ($rose(clock_invalid_flag) |->
        $past(main_power_ok) && !$past(main_power_ok, 2))
        else $error("flag raised without power return");
    AST_FLAG_FALL: assert property ($fell(clock_invalid_flag) |->
        $past(apply_w)) else $error("flag cleared without a set");

    // Main scenarios
    cover property (pready && pslverr);
    cover property ($rose(clock_invalid_flag));
    cover property ($rose(irq));
endmodule : bcc_clock_asserts

bind bcc_clock bcc_clock_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_power_ok(main_power_ok),
    .clock_invalid_flag(clock_invalid_flag), .irq(irq)
);

//--- dv/tb_bcd_clock_calendar.sv
// Self-checking bench of the BCD clock calendar
`timescale 1ns/100ps
module tb_bcd_clock_calendar;
    localparam int TICK = 200;
    // Row: staged time with expected weekday, then time after one tick
    typedef struct packed {
        bcc_pkg::bcc_time_t set;
        bcc_pkg::bcc_time_t nxt;
    } bcc_row_t;
    localparam bcc_row_t ROWS [6] = '{
        112'h24022823595903_24022900000004, // Leap February
        112'h23123123595900_24010100000001, // Year carry
        112'h23022823595902_23030100000003, // Common February
        112'h24043023595902_24050100000003, // Thirty-day month
        112'h00010100005906_00010100010006, // Minute carry
        112'h24070412595904_24070413000004  // Hour carry
    };

    logic        pclk, presetn, psel, penable, pwrite, main_power_ok;
    logic        pready, pslverr, flag, irq, e, mid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    int          err_total = 0;
    int          comparisons = 0;
    int          cycles = 0;

    bcc_clock #(.TICK_CYCLES(TICK), .BACKUP_S(3)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .main_power_ok(main_power_ok),
        .clock_invalid_flag(flag), .irq(irq)
    );

    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic report_and_stop();
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Cycle budget cuts a hung handshake short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer; an idle cycle after it keeps drives one per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), exp, q);
    endtask : rd

    task automatic rd_time(input bcc_pkg::bcc_time_t t);
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), {24'h0, t[55 - 8 * i -: 8]});
        end
    endtask : rd_time

    task automatic set_time(input bcc_pkg::bcc_time_t t);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'(8'h20 + 4 * i), {24'h0, t[55 - 8 * i -: 8]});
        end
        apb(1'b1, 8'h38, 32'h1);
    endtask : set_time

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        main_power_ok = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Power-up contents, flag raised, mask clear
        rd_time(56'h00010100000006);
        chk("flag", 32'h1, {31'h0, flag});
        rd(8'h3c, 32'h3);
        rd(8'h44, 32'h0);
        // Unmapped place refused, time registers read-only
        apb(1'b0, 8'h48, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        apb(1'b1, 8'h00, 32'h55);
        rd(8'h00, 32'h0);
        apb(1'b1, 8'h44, 32'h1);
        // Table of set and carry cases; old events cleared after apply
        foreach (ROWS[k]) begin
            set_time(ROWS[k].set);
            apb(1'b0, 8'h40, 32'h0);
            rd_time(ROWS[k].set);
            chk("flag", 32'h0, {31'h0, flag});
            do @(posedge pclk); while (irq !== 1'b1);
            mid = ROWS[k].nxt[31:8] == 24'h0;
            rd(8'h40, {30'h0, mid, 1'b1});
            // The line lags the cleared status by one cycle
            @(posedge pclk);
            chk("irq", 32'h0, {31'h0, irq});
            rd_time(ROWS[k].nxt);
        end
        // Masked tick: status still sticky, line stays low
        apb(1'b1, 8'h44, 32'h0);
        repeat (TICK + 20) @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(8'h40, 32'h1);
        // Power lost: three seconds of backup, then time stops
        set_time(56'h00010100000000);
        main_power_ok <= 1'b0;
        repeat (6 * TICK) @(posedge pclk);
        rd(8'h3c, 32'h4);
        main_power_ok <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("flag", 32'h1, {31'h0, flag});
        rd(8'h14, 32'h3);
        apb(1'b0, 8'h40, 32'h0);
        chk("sts", 32'h4, q & 32'h4);
        // Reset in mid-run restores power-up time and flag
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("flag", 32'h1, {31'h0, flag});
        rd_time(56'h00010100000006);
        report_and_stop();
    end
endmodule : tb_bcd_clock_calendar
